/* mesb_pkg.sv */
// Purpose: Constants and types for the motion event status bank
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   Printed offsets are not word multiples, so they are indices
package mesb_pkg;

  // ****************************************************************
  // Register indices and addresses
  // ****************************************************************
  localparam logic [7:0]  MESB_IDX_STAMP_CFG = 8'h18;
  localparam logic [7:0]  MESB_IDX_TS_CTRL   = 8'h19;
  localparam logic [7:0]  MESB_IDX_ALL_SRC   = 8'h1a;
  localparam logic [7:0]  MESB_IDX_WAKE_SRC  = 8'h1b;
  localparam logic [7:0]  MESB_IDX_TAP_EVENT_SOURCE   = 8'h1c;
  localparam logic [7:0]  MESB_IDX_TS0       = 8'h40;
  localparam logic [7:0]  MESB_IDX_TS3       = 8'h43;
  localparam logic [7:0]  MESB_IDX_DRDY_CFG  = 8'h0b;
  localparam logic [7:0]  MESB_IDX_STAMP_ST  = 8'h1d;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          MESB_B_AXIS_LO     = 5;
  localparam int          MESB_B_SENSOR_SEL  = 4;
  localparam int          MESB_B_ACCEL_EXT   = 3;
  localparam int          MESB_B_POLARITY    = 2;
  localparam int          MESB_B_I3C_OFF     = 1;
  localparam int          MESB_B_TS_EN       = 5;
  localparam int          MESB_B_PULSED      = 7;
  localparam logic [7:0]  MESB_RST_STAMP_CFG = 8'he0;
  localparam logic [7:0]  MESB_RST_TS_CTRL   = 8'h00;
  localparam logic [7:0]  MESB_RST_DRDY_CFG  = 8'h00;

  // ****************************************************************
  // Timing: timestamp counter and near-wrap window
  // ****************************************************************
  localparam int          MESB_CLK_HZ        = 40000000;
  localparam int          MESB_WARN_US       = 6400;
  localparam longint      MESB_WARN_CYC      =
    (longint'(MESB_WARN_US) * MESB_CLK_HZ) / 1000000;
  localparam logic [31:0] MESB_TS_TICK_CYC   = 32'h000003e8;

  // ****************************************************************
  // Event inputs from the detection engines
  // ****************************************************************
  typedef struct packed {
    logic       free_fall;
    logic       wake;
    logic [2:0] wake_axis;   // X, Y, Z
    logic       sleep_state;
    logic       activity_change;
    logic       orientation;
    logic       single_tap;
    logic       double_tap;
    logic       tap_sign;
    logic [2:0] tap_axis;    // X, Y, Z
  } mesb_event_s;

  typedef enum logic [1:0] {
    MESB_APB_IDLE   = 2'b01,
    MESB_APB_ACCESS = 2'b10
  } mesb_apb_e;

endpackage : mesb_pkg

/* mesb_bank.sv */
// Purpose: Control and event source register bank behind APB
// Assumes: Event inputs other than sleep_state are one-cycle detection pulses, synchronous
// Notes:   Source flags clear on read of their register; set wins
//          An access counts only after its own setup cycle
`timescale 1ns/100ps
module mesb_bank
  import mesb_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [9:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire mesb_event_s EVENTS,
  input  wire logic        STAMP_PIN,
  input  wire logic        SAMPLE_STROBE,
  input  wire logic [15:0] GYRO_IN [3],
  input  wire logic [15:0] ACCEL_IN [3],
  output logic      [15:0] GYRO_OUT [3],
  output logic      [15:0] ACCEL_OUT [3],
  output logic             STAMP_DRDY,
  output logic             I3C_DISABLE
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic [7:0]  idx;
  logic        hit_stamp;
  logic        hit_ts_ctrl;
  logic        hit_all;
  logic        hit_wake;
  logic        hit_tap;
  logic        hit_drdy;
  logic        hit_stamp_st;
  logic        hit_ts;
  logic        bus_ok;
  logic        in_access;
  logic        wr_en;
  logic        rd_en;
  mesb_apb_e   apb_q;

  // Index decode, one hit per mapped register; the four timestamp bytes share hit_ts
  assign idx          = PADDR[9:2];
  assign hit_stamp    = (idx == MESB_IDX_STAMP_CFG);
  assign hit_ts_ctrl  = (idx == MESB_IDX_TS_CTRL);
  assign hit_all      = (idx == MESB_IDX_ALL_SRC);
  assign hit_wake     = (idx == MESB_IDX_WAKE_SRC);
  assign hit_tap      = (idx == MESB_IDX_TAP_EVENT_SOURCE);
  assign hit_drdy     = (idx == MESB_IDX_DRDY_CFG);
  assign hit_stamp_st = (idx == MESB_IDX_STAMP_ST);
  assign hit_ts       = (idx >= MESB_IDX_TS0) && (idx <= MESB_IDX_TS3);

  // Unaligned byte addresses are refused outright
  assign bus_ok = (PADDR[1:0] == 2'h0) &&
                  (hit_stamp || hit_ts_ctrl || hit_all || hit_wake ||
                   hit_tap || hit_drdy || hit_stamp_st || hit_ts);

  // Zero wait states: every access ends in its first access cycle
  assign PREADY    = 1'b1;
  assign in_access = PSEL & PENABLE & (apb_q == MESB_APB_ACCESS);
  assign PSLVERR   = in_access & ~bus_ok;
  assign wr_en     = in_access & PWRITE & bus_ok;
  assign rd_en     = in_access & ~PWRITE & bus_ok;

  // Phase tracker: an enable seen without a setup cycle before it
  // is not an access, so it can neither write nor clear a flag
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      apb_q <= MESB_APB_IDLE;
    end else begin
      case (apb_q)
        MESB_APB_IDLE: begin
          if (PSEL && !PENABLE) begin
            apb_q <= MESB_APB_ACCESS;
          end
        end
        MESB_APB_ACCESS: apb_q <= MESB_APB_IDLE;
        default:         apb_q <= MESB_APB_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Writable configuration
  // ****************************************************************
  logic [7:0] stamp_cfg_q;
  logic [7:0] ts_ctrl_q;
  logic [7:0] drdy_cfg_q;

  // Stamp config: bit 0 is stored as written; host keeps it zero
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      stamp_cfg_q <= MESB_RST_STAMP_CFG;
    end else if (wr_en && hit_stamp) begin
      stamp_cfg_q <= PWDATA[7:0];
    end
  end

  // Timestamp control: only the enable bit is kept
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ts_ctrl_q <= MESB_RST_TS_CTRL;
    end else if (wr_en && hit_ts_ctrl) begin
      ts_ctrl_q <= PWDATA[7:0] & 8'h20;
    end
  end

  // Data-ready mode: only the pulsed bit is kept
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      drdy_cfg_q <= MESB_RST_DRDY_CFG;
    end else if (wr_en && hit_drdy) begin
      drdy_cfg_q <= PWDATA[7:0] & 8'h80;
    end
  end

  assign I3C_DISABLE = stamp_cfg_q[MESB_B_I3C_OFF];

  // ****************************************************************
  // Timestamp counter and near-wrap warning
  // ****************************************************************
  logic [31:0] tick_q;
  logic [31:0] ts_q;
  logic        ts_en;
  logic        near_wrap;
  localparam logic [31:0] WARN_TICKS =
    32'((MESB_WARN_CYC + longint'(MESB_TS_TICK_CYC) - 1)
        / longint'(MESB_TS_TICK_CYC));

  assign ts_en = ts_ctrl_q[MESB_B_TS_EN];

  // Divider gives one tick enable per counter step
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || !ts_en) begin
      tick_q <= 32'h0;
    end else if (tick_q == MESB_TS_TICK_CYC - 32'h1) begin
      tick_q <= 32'h0;
    end else begin
      tick_q <= tick_q + 32'h1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ts_q <= 32'h0;
    end else if (ts_en && tick_q == MESB_TS_TICK_CYC - 32'h1) begin
      ts_q <= ts_q + 32'h1;
    end
  end

  // Warning is a level while the counter sits in its last window
  assign near_wrap = ts_en && (ts_q >= (32'hffffffff - WARN_TICKS));

  // ****************************************************************
  // Event flags: sticky, cleared by reading their register; sleep state is a level and tap sign is never cleared
  // ****************************************************************
  logic all_rd;
  logic wake_rd;
  logic tap_rd;
  logic ff_q, wu_q, ac_q, or_q, st_q, dt_q, tap_q, sgn_q, slp_q;
  logic [2:0] wax_q;
  logic [2:0] tax_q;

  assign all_rd  = rd_en && (idx == MESB_IDX_ALL_SRC);
  assign wake_rd = rd_en && (idx == MESB_IDX_WAKE_SRC);
  assign tap_rd  = rd_en && (idx == MESB_IDX_TAP_EVENT_SOURCE);

  // Free-fall: one flag feeds both views so copies never diverge;
  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ff_q <= 1'b0;
    end else begin
      ff_q <= EVENTS.free_fall | (ff_q & ~(all_rd | wake_rd));
    end
  end

  // Wake-up overall flag, shared by both views
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      wu_q <= 1'b0;
    end else begin
      wu_q <= EVENTS.wake | (wu_q & ~(all_rd | wake_rd));
    end
  end

  // Wake axes live only in the wake view
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      wax_q <= 3'h0;
    end else begin
      wax_q <= EVENTS.wake_axis | (wax_q & {3{~wake_rd}});
    end
  end

  // Activity change, shared by both views
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ac_q <= 1'b0;
    end else begin
      ac_q <= EVENTS.activity_change |
              (ac_q & ~(all_rd | wake_rd));
    end
  end

  // Orientation change; the stamp status view does not clear it
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      or_q <= 1'b0;
    end else begin
      or_q <= EVENTS.orientation | (or_q & ~all_rd);
    end
  end

  // Single tap, shared by the combined and tap views
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_q <= 1'b0;
    end else begin
      st_q <= EVENTS.single_tap | (st_q & ~(all_rd | tap_rd));
    end
  end

  // Double tap, shared by the combined and tap views
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      dt_q <= 1'b0;
    end else begin
      dt_q <= EVENTS.double_tap | (dt_q & ~(all_rd | tap_rd));
    end
  end

  // General tap flag, set by either kind of tap
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      tap_q <= 1'b0;
    end else begin
      tap_q <= (EVENTS.single_tap | EVENTS.double_tap) |
               (tap_q & ~tap_rd);
    end
  end

  // Tap axes live only in the tap view
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      tax_q <= 3'h0;
    end else begin
      tax_q <= EVENTS.tap_axis | (tax_q & {3{~tap_rd}});
    end
  end

  // Tap sign follows the latest tap of either kind
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sgn_q <= 1'b0;
    end else if (EVENTS.single_tap || EVENTS.double_tap) begin
      sgn_q <= EVENTS.tap_sign;
    end
  end

  // Sleep state is a status level, not a sticky event
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      slp_q <= 1'b0;
    end else begin
      slp_q <= EVENTS.sleep_state;
    end
  end

  // ****************************************************************
  // Stamping of the external pin into sample LSBs
  // ****************************************************************
  logic       pin_active;
  logic       to_accel;
  logic       to_gyro;
  logic [2:0] axis_sel;
  logic       drdy_q;
  logic       stat_rd;

  assign pin_active = STAMP_PIN ~^ stamp_cfg_q[MESB_B_POLARITY];
  assign axis_sel   = stamp_cfg_q[MESB_B_AXIS_LO +: 3];
  assign to_accel   = stamp_cfg_q[MESB_B_SENSOR_SEL] &
                      stamp_cfg_q[MESB_B_ACCEL_EXT];
  assign to_gyro    = ~stamp_cfg_q[MESB_B_SENSOR_SEL];
  assign stat_rd    = rd_en && hit_stamp_st;

  // Axis 0 is X, which sits in the top select bit
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_axis
      always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
          GYRO_OUT[gi]  <= 16'h0;
          ACCEL_OUT[gi] <= 16'h0;
        end else if (SAMPLE_STROBE) begin
          GYRO_OUT[gi]  <= {GYRO_IN[gi][15:1],
            (to_gyro && axis_sel[2-gi]) ? pin_active
                                         : GYRO_IN[gi][0]};
          ACCEL_OUT[gi] <= {ACCEL_IN[gi][15:1],
            (to_accel && axis_sel[2-gi]) ? pin_active
                                          : ACCEL_IN[gi][0]};
        end
      end
    end
  endgenerate

  // Data-ready: a strobe with the pin active sets it; pulsed mode drops
  // it on the next edge, latched mode holds it until the status is read
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      drdy_q <= 1'b0;
    end else begin
      drdy_q <= (SAMPLE_STROBE & pin_active) |
                (drdy_q & ~drdy_cfg_q[MESB_B_PULSED] & ~stat_rd);
    end
  end
  assign STAMP_DRDY = drdy_q;

  // ****************************************************************
  // Read data mux
  // ****************************************************************
  logic [7:0] all_view;
  logic [7:0] wake_view;
  logic [7:0] tap_view;
  logic [7:0] stat_view;
  logic [7:0] rd_byte;

  // Each view is built once from the shared flags, so a flag shown in
  // two registers can never read differently between them
  assign all_view  = {near_wrap, 1'b0, ac_q, or_q,
                      dt_q, st_q, wu_q, ff_q};
  assign wake_view = {1'b0, ac_q, ff_q, slp_q,
                      wu_q, wax_q};
  assign tap_view  = {1'b0, tap_q, st_q, dt_q,
                      sgn_q, tax_q};
  assign stat_view = {drdy_q, or_q, 6'h0};

  // Source registers have no write path at all; unmapped reads give 0
  always_comb begin
    rd_byte = 8'h0;
    if (hit_stamp) begin
      rd_byte = stamp_cfg_q;
    end else if (hit_ts_ctrl) begin
      rd_byte = ts_ctrl_q;
    end else if (hit_drdy) begin
      rd_byte = drdy_cfg_q;
    end else if (hit_all) begin
      rd_byte = all_view;
    end else if (hit_wake) begin
      rd_byte = wake_view;
    end else if (hit_tap) begin
      rd_byte = tap_view;
    end else if (hit_stamp_st) begin
      rd_byte = stat_view;
    end else if (hit_ts) begin
      rd_byte = ts_q[8 * (idx - MESB_IDX_TS0) +: 8];
    end
  end

  // Registering read data would need a wait state and would race the
  // clear-on-read flags, so the mux output goes straight out
  assign PRDATA = (rd_en) ? {24'h0, rd_byte} : 32'h0;

endmodule : mesb_bank

/* mesb_checker.sv */
// Purpose: Port assertions for the event status bank
// Assumes: Zero-wait APB slave, byte address is index times four
// Notes:   Bound into every mesb_bank
`timescale 1ns/100ps
module mesb_checker
  import mesb_pkg::*;
(
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [9:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire mesb_event_s EVENTS,
  input wire logic        I3C_DISABLE
);
  // Access phase decode
  wire acc = PSEL && PENABLE;
  wire rd  = acc && !PWRITE;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  // Host never stalls: zero wait states
  ready_high_a: assert property (PREADY) else $error("ready low");
  idle_quiet_a: assert property (!acc |-> PRDATA == 32'h0 && !PSLVERR)
    else $error("bus busy when idle");
  bad_addr_a: assert property (acc && PADDR[1:0] != 2'h0 |-> PSLVERR)
    else $error("unaligned accepted");
  i3c_follow_a: assert property (acc && PWRITE && PADDR == 10'h060
    |=> I3C_DISABLE == $past(PWDATA[1])) else $error("i3c bit lost");
  all_gap_a: assert property (rd && PADDR == 10'h068
    |-> !PRDATA[6] && PRDATA[31:8] == 24'h0) else $error("gap bit set");
  sleep_view_a: assert property (rd && PADDR == 10'h06c
    && $stable(EVENTS.sleep_state) |-> PRDATA[4] == EVENTS.sleep_state)
    else $error("sleep bit wrong");
  tap_top_a: assert property (rd && PADDR == 10'h070
    |-> PRDATA[31:7] == 25'h0) else $error("tap top bits set");
  mapped_ok_a: assert property (acc && PADDR inside {10'h060, 10'h064,
    10'h068, 10'h06c, 10'h070} |-> !PSLVERR) else $error("mapped refused");
endmodule : mesb_checker

bind mesb_bank mesb_checker u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .EVENTS(EVENTS), .I3C_DISABLE(I3C_DISABLE));

/* mesb_src_model.sv */
// Purpose: Detection engine and sample source feeding the bank
// Assumes: Tasks are called by the bench
// Notes:   Sample lanes scramble once the strobe has gone
`timescale 1ns/100ps
module mesb_src_model
  import mesb_pkg::*;
(
  input  wire logic        clk,
  output mesb_event_s      events,
  output logic             pin,
  output logic             strobe,
  output logic      [15:0] gyro [3],
  output logic      [15:0] accel [3]
);
  // Quiet at time zero
  initial begin
    events = '0;
    pin = 1'b1;
    strobe = 1'b0;
    gyro = '{16'h0, 16'h0, 16'h0};
    accel = '{16'h0, 16'h0, 16'h0};
  end

  // One-cycle pulse; sleep state stays as a level
  task automatic fire(input mesb_event_s e);
    mesb_event_s h;
    h = '0;
    h.sleep_state = e.sleep_state;
    @(posedge clk);
    events <= e;
    @(posedge clk);
    events <= h;
  endtask : fire

  // Inverted lanes after the strobe catch a late capture
  task automatic sample(input logic p, input logic [15:0] g, a);
    @(posedge clk);
    pin <= p;
    strobe <= 1'b1;
    gyro <= '{g, g, g};
    accel <= '{a, a, a};
    @(posedge clk);
    strobe <= 1'b0;
    gyro <= '{~g, ~g, ~g};
    accel <= '{~a, ~a, ~a};
  endtask : sample
endmodule : mesb_src_model

/* tb.sv */
// Purpose: Self-checking bench for the event status bank
// Assumes: Zero-wait APB slave
// Notes:   Flags clear on read, so read order matters
`timescale 1ns/100ps
module tb
  import mesb_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [9:0]  paddr = 10'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        serr;
  logic        i3c;
  logic        drdy;
  logic        pin;
  logic        strobe;
  mesb_event_s events;
  logic [15:0] gyro_in [3];
  logic [15:0] accel_in [3];
  logic [15:0] gyro_out [3];
  logic [15:0] accel_out [3];
  int          errors = 0;
  int          total_checks = 0;

  // 40 MHz
  always #12.5 clk = ~clk;

  mesb_bank dut (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EVENTS(events),
    .STAMP_PIN(pin), .SAMPLE_STROBE(strobe), .GYRO_IN(gyro_in),
    .ACCEL_IN(accel_in), .GYRO_OUT(gyro_out), .ACCEL_OUT(accel_out),
    .STAMP_DRDY(drdy), .I3C_DISABLE(i3c));
  mesb_src_model src (.clk(clk), .events(events), .pin(pin),
    .strobe(strobe), .gyro(gyro_in), .accel(accel_in));

  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Request held until pready is seen high
  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  // Config, one sample, then the Y lanes
  task automatic stamp(input logic [7:0] c, input logic p,
                       input logic [15:0] g, a, eg, ea);
    wr(10'h060, {24'h0, c});
    src.sample(p, g, a);
    @(negedge clk);
    chk({16'h0, gyro_out[1]}, {16'h0, eg});
    chk({16'h0, accel_out[1]}, {16'h0, ea});
  endtask : stamp

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    logic [31:0] q;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(10'h060, 32'he0);
    rd(10'h064, 32'h00);
    rd(10'h068, 32'h00);
    rd(10'h06c, 32'h00);
    rd(10'h070, 32'h00);
    wr(10'h060, 32'he2);
    @(negedge clk);
    chk(32'(i3c), 32'h1);
    rd(10'h060, 32'he2);
    stamp(8'he2, 1'b0, 16'h1234, 16'h0f0e, 16'h1235, 16'h0f0e);
    stamp(8'h5c, 1'b1, 16'h1234, 16'h0f0e, 16'h1234, 16'h0f0f);
    stamp(8'h44, 1'b0, 16'h1235, 16'h0f0f, 16'h1234, 16'h0f0f);
    rd(10'h074, 32'h80);
    rd(10'h074, 32'h00);
    @(negedge clk);
    chk(32'(drdy), 32'h0);
    wr(10'h02c, 32'h80);
    rd(10'h02c, 32'h80);
    stamp(8'h44, 1'b1, 16'h1234, 16'h0f0e, 16'h1235, 16'h0f0e);
    chk(32'(drdy), 32'h1);
    @(negedge clk);
    chk(32'(drdy), 32'h0);
    src.fire('{free_fall: 1'b1, wake: 1'b1, wake_axis: 3'b100,
      default: '0});
    rd(10'h06c, 32'h2c);
    rd(10'h068, 32'h00);
    src.fire('{single_tap: 1'b1, tap_sign: 1'b1, tap_axis: 3'b001,
      default: '0});
    rd(10'h068, 32'h04);
    rd(10'h070, 32'h49);
    src.fire('{double_tap: 1'b1, tap_axis: 3'b010, orientation: 1'b1,
      activity_change: 1'b1, sleep_state: 1'b1, default: '0});
    rd(10'h070, 32'h52);
    rd(10'h068, 32'h30);
    rd(10'h06c, 32'h10);
    src.fire('{wake: 1'b1, wake_axis: 3'b001, sleep_state: 1'b1,
      default: '0});
    wr(10'h06c, 32'hff);
    rd(10'h06c, 32'h19);
    wr(10'h064, 32'h20);
    rd(10'h064, 32'h20);
    repeat (2100) @(posedge clk);
    apb(1'b0, 10'h100, 32'h0, q);
    chk(32'(q >= 32'h2 && q <= 32'h3), 32'h1);
    rd(10'h068, 32'h00);
    apb(1'b0, 10'h3fc, 32'h0, q);
    chk(32'(serr), 32'h1);
    wr(10'h061, 32'h00);
    chk(32'(serr), 32'h1);
    rd(10'h060, 32'h44);
    final_report();
  end

  // Run needs about 2200 cycles; cut a hang at 10000
  initial begin
    #(25 * 10000);
    errors++;
    final_report();
  end
endmodule : tb
